/* src/adc_port_pkg.sv */
// constants and types for the serial converter port
//
// Behaviour
// [R01] port active only while select low
// [R02] select high powers converter down (mux variant)
// [R03] mux variant powers down when idle
// [R04] host clocks at 14.4MHz for fastest rate
// [R05] fixed variant: first clock enables output
// [R06] two null bits precede result
// [R07] select high resets serial state
// [R08] config bits sampled on rising edge
// [R09] result bit changes rising, host latches next
// [R10] leading zeros ignored, first one starts
// [R11] four-bit word: address then two dummies
// [R12] further input ignored until select cycles
// [R13] address bits pick channel pair, polarity
// [R14] single-ended measures channel against ground
// [R15] dummy bits ignored, give acquisition time
// [R16] result msb first, then zeros forever
// [R17] fixed variant takes no config word
// [R18] unipolar coding only
// [R19] result is eight bits
// [R20] shared wire driven on fifth falling edge
// [R21] host releases wire before device drives
// [R22] sampling begins before first dummy bit
// [R23] conversion lasts 8.5 clock cycles
// [R24] output high-impedance when not driving
// [R25] select one means single-ended
package adc_port_pkg;
   localparam int unsigned RESULT_W = 8;
   localparam int unsigned CONFIG_W = 4;
   localparam int unsigned NULL_BITS = 2;
   localparam logic [3:0] CNT_W0 = 4'h0;
   localparam logic [4:0] CONV_HALF_CYCLES = 5'h11;
   localparam logic [4:0] CONV_W0 = 5'h00;
   localparam logic [3:0] DRIVE_FALL_EDGE = 4'h5;
   localparam logic [3:0] FALLS_MAX = 4'hf;
   localparam logic [3:0] SGL_SLOT = 4'h0;
   localparam logic [3:0] ODD_SLOT = 4'h1;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_CONFIG = 3'b010,
      ST_NULL = 3'b011,
      ST_DATA = 3'b100,
      ST_ZERO = 3'b101
   } port_state_t;
endpackage

/* src/adc_serial_port.sv */
// serial port and sequencer of an 8-bit sampling converter
`timescale 1ns/1ps
module adc_serial_port (
   // system
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // variant strap: 1 = two-channel multiplexed
   input wire logic mux_variant_i,
   // serial pins, sampled synchronously
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic din_i,
   output logic dout_o,
   output logic dout_oe_o,
   // converter core
   input wire logic [7:0] conv_data_i,
   output logic powered_o,
   output logic sample_o,
   output logic convert_o,
   output logic single_ended_select_o,
   output logic odd_sign_o,
   output logic [7:0] result_o
);
   // ---------------------------------------------
   // state and counters
   // ---------------------------------------------
   adc_port_pkg::port_state_t state_reg;
   adc_port_pkg::port_state_t state_next;
   logic sclk_reg;
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic [3:0] falls_reg;
   logic [3:0] falls_next;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic [4:0] conv_reg;
   logic [4:0] conv_next;
   logic started_reg;
   logic started_next;

   // ---------------------------------------------
   // next values of the output flops
   // ---------------------------------------------
   logic dout_next;
   logic dout_oe_next;
   logic powered_next;
   logic sample_next;
   logic convert_next;
   logic single_ended_select_next;
   logic odd_sign_next;
   logic [7:0] result_next;

   // ---------------------------------------------
   // shift clock edge decode
   // ---------------------------------------------
   // sclk is a plain input sampled on core_clk, so an edge is seen
   // one core_clk after the pin moves
   wire rise = sclk_i & ~sclk_reg; // R08 R09
   wire fall = ~sclk_i & sclk_reg;
   wire active = ~cs_n_i; // R01
   // a high select clears the serial state like a reset
   wire clear = ~rstn_i | ~active; // R07

   // ---------------------------------------------
   // state decode
   // ---------------------------------------------
   wire in_idle = (state_reg == adc_port_pkg::ST_IDLE);
   wire in_start = (state_reg == adc_port_pkg::ST_START);
   wire in_config = (state_reg == adc_port_pkg::ST_CONFIG);
   wire in_null = (state_reg == adc_port_pkg::ST_NULL);
   wire in_data = (state_reg == adc_port_pkg::ST_DATA);
   wire in_zero = (state_reg == adc_port_pkg::ST_ZERO);

   // ---------------------------------------------
   // event decode
   // ---------------------------------------------
   // leading zeros never leave the start state
   wire start_seen = in_start & rise & din_i; // R10
   // fixed variant: no word, first clock starts everything
   wire fixed_go = in_idle & ~mux_variant_i & rise; // R05 R17
   wire cfg_rise = in_config & rise; // R11
   wire sgl_take = cfg_rise & (cnt_reg == adc_port_pkg::SGL_SLOT); // R13 R25
   wire odd_take = cfg_rise & (cnt_reg == adc_port_pkg::ODD_SLOT); // R14
   wire cfg_last = cfg_rise & (cnt_reg == 4'(adc_port_pkg::CONFIG_W - 1)); // R12
   // hold starts on the fall after the second dummy bit
   wire hold_start = in_null & sample_o & fall; // R22
   wire conv_start = fixed_go | hold_start;
   wire null_rise = in_null & rise; // R06
   wire null_last = null_rise & (cnt_reg == 4'(adc_port_pkg::NULL_BITS));
   wire data_rise = in_data & rise; // R16
   wire data_last = data_rise & (cnt_reg == 4'(adc_port_pkg::RESULT_W));
   wire zero_rise = in_zero & rise; // R16
   // conversion is timed in sclk half periods
   wire conv_edge = convert_o & (rise | fall);
   wire conv_done = conv_edge & ((conv_reg + 5'h01) == adc_port_pkg::CONV_HALF_CYCLES); // R23
   // falls counted from the start bit, saturating
   wire fall_count = started_reg & fall & (falls_reg != adc_port_pkg::FALLS_MAX);
   wire drive_fall = fall_count & ((falls_reg + 4'h1) == adc_port_pkg::DRIVE_FALL_EDGE); // R20

   // ---------------------------------------------
   // next value selection
   // ---------------------------------------------
   assign cnt_next = fixed_go ? adc_port_pkg::CNT_W0 :
      start_seen ? adc_port_pkg::CNT_W0 :
      cfg_last ? adc_port_pkg::CNT_W0 :
      cfg_rise ? cnt_reg + 4'h1 :
      null_last ? 4'h1 :
      null_rise ? cnt_reg + 4'h1 :
      data_rise ? cnt_reg + 4'h1 :
      cnt_reg;

   assign falls_next = fall_count ? falls_reg + 4'h1 : falls_reg;

   assign started_next = start_seen | started_reg;

   assign conv_next = conv_edge ? conv_reg + 5'h01 : conv_reg;

   // result leaves msb first, zeros shift in behind it
   assign shift_next = conv_start ? conv_data_i :
      (null_last | data_rise) ? {shift_reg[6:0], 1'b0} :
      shift_reg; // R16 R18 R19

   assign result_next = conv_start ? conv_data_i : result_o; // R19

   assign dout_next = null_last ? shift_reg[7] :
      null_rise ? 1'b0 :
      data_last ? 1'b0 :
      data_rise ? shift_reg[7] :
      zero_rise ? 1'b0 :
      dout_o; // R06 R09 R16

   // driver stays on until select goes high
   assign dout_oe_next = fixed_go | drive_fall | dout_oe_o; // R05 R20 R24

   // mux variant draws power only from start bit to end of conversion
   assign powered_next = in_idle ? ~mux_variant_i :
      start_seen ? 1'b1 :
      (conv_done & mux_variant_i) ? 1'b0 :
      powered_o; // R03

   // fixed variant tracks its input until the first clock
   assign sample_next = (in_idle & ~mux_variant_i) ? ~rise :
      odd_take ? 1'b1 :
      hold_start ? 1'b0 :
      sample_o; // R15 R22

   assign convert_next = conv_start ? 1'b1 :
      conv_done ? 1'b0 :
      convert_o; // R23

   assign single_ended_select_next = sgl_take ? din_i : single_ended_select_o; // R13 R25

   assign odd_sign_next = odd_take ? din_i : odd_sign_o; // R14

   // ---------------------------------------------
   // sequencer
   // ---------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         adc_port_pkg::ST_IDLE: begin
            if (mux_variant_i) begin
               state_next = adc_port_pkg::ST_START;
            end else if (rise) begin
               state_next = adc_port_pkg::ST_NULL; // R17
            end
         end
         adc_port_pkg::ST_START: begin
            if (start_seen) begin
               state_next = adc_port_pkg::ST_CONFIG; // R10
            end
         end
         adc_port_pkg::ST_CONFIG: begin
            if (cfg_last) begin
               // the rest of din is ignored from here on
               state_next = adc_port_pkg::ST_NULL; // R12
            end
         end
         adc_port_pkg::ST_NULL: begin
            if (null_last) begin
               state_next = adc_port_pkg::ST_DATA; // R06
            end
         end
         adc_port_pkg::ST_DATA: begin
            if (data_last) begin
               state_next = adc_port_pkg::ST_ZERO; // R16
            end
         end
         adc_port_pkg::ST_ZERO: begin
            state_next = adc_port_pkg::ST_ZERO;
         end
         default: begin
            state_next = adc_port_pkg::ST_IDLE;
         end
      endcase
   end

   // ---------------------------------------------
   // edge detector flop
   // ---------------------------------------------
   // resets to the idle level of sclk so no false edge follows reset
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         sclk_reg <= 1'b0;
      end else begin
         sclk_reg <= sclk_i;
      end
   end

   // ---------------------------------------------
   // internal registers
   // ---------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (clear) begin
         state_reg <= adc_port_pkg::ST_IDLE; // R07
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (clear) begin
         cnt_reg <= adc_port_pkg::CNT_W0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (clear) begin
         falls_reg <= adc_port_pkg::CNT_W0;
      end else begin
         falls_reg <= falls_next;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (clear) begin
         started_reg <= 1'b0;
      end else begin
         started_reg <= started_next;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (clear) begin
         conv_reg <= adc_port_pkg::CONV_W0;
      end else begin
         conv_reg <= conv_next;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (clear) begin
         shift_reg <= 8'h00;
      end else begin
         shift_reg <= shift_next;
      end
   end

   // ---------------------------------------------
   // serial output flops
   // ---------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (clear) begin
         dout_o <= 1'b0;
      end else begin
         dout_o <= dout_next;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (clear) begin
         dout_oe_o <= 1'b0; // R24
      end else begin
         dout_oe_o <= dout_oe_next;
      end
   end

   // ---------------------------------------------
   // converter core flops
   // ---------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (clear) begin
         powered_o <= 1'b0; // R02
      end else begin
         powered_o <= powered_next;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (clear) begin
         sample_o <= 1'b0;
      end else begin
         sample_o <= sample_next;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (clear) begin
         convert_o <= 1'b0;
      end else begin
         convert_o <= convert_next;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (clear) begin
         result_o <= 8'h00;
      end else begin
         result_o <= result_next;
      end
   end

   // ---------------------------------------------
   // captured address bits
   // ---------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (clear) begin
         single_ended_select_o <= 1'b0;
      end else begin
         single_ended_select_o <= single_ended_select_next;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (clear) begin
         odd_sign_o <= 1'b0;
      end else begin
         odd_sign_o <= odd_sign_next;
      end
   end

   // ---------------------------------------------
   // notes for users of this port
   // ---------------------------------------------
   // the word is taken on sclk rises, the result also changes on rises
   // the output driver never drops inside a frame
   // a cut frame is ended by the select going high, which
   // returns every flop above except sclk_reg to its idle value
   // the mux variant counts sclk falls from the start bit so the
   // shared wire is only taken after the host has let go of it
   // the conversion length is counted in half periods of sclk,
   // so it scales with whatever rate the host runs the clock at
   // the fixed variant keeps powered high while selected, only
   // the mux variant drops power between conversions
   // the captured result stays on result_o until select goes high
   // the address bits stay on their outputs until select goes high
   // the dummy bits are clocked past without being stored
   // any clock after the last result bit only shifts out zeros
endmodule

/* tb/adc_serial_port_properties.sv */
// pin-level assertions for the serial converter port
`timescale 1ns/1ps
module adc_serial_port_properties (
   // watched pins
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic mux_variant_i,
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic dout_o,
   input wire logic dout_oe_o,
   input wire logic powered_o,
   input wire logic sample_o,
   input wire logic convert_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   property p_idle_off; cs_n_i [*3] |-> !dout_oe_o && !convert_o && !powered_o; endproperty
   a_idle_off: assert property (p_idle_off) else $error("active while deselected");
   property p_oe_holds; !cs_n_i [*4] ##0 $past(dout_oe_o) |-> dout_oe_o; endproperty
   a_oe_holds: assert property (p_oe_holds) else $error("driver dropped in frame");
   property p_dout_rise; $changed(dout_o) && dout_oe_o && $past(dout_oe_o) |->
      $past(sclk_i) || $past(sclk_i, 2); endproperty
   a_dout_rise: assert property (p_dout_rise) else $error("output moved off rise");
   property p_conv_len; $rose(convert_o) |-> ##[66:70] $fell(convert_o); endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
   property p_sample_first; mux_variant_i && $rose(convert_o) |-> $past(sample_o); endproperty
   a_sample_first: assert property (p_sample_first) else $error("hold without sampling");
   property p_acq; mux_variant_i && $rose(sample_o) |-> ##[19:21] $rose(convert_o); endproperty
   a_acq: assert property (p_acq) else $error("acquisition window wrong");
   property p_mux_oe; mux_variant_i && $rose(dout_oe_o) |-> !$past(sclk_i) && !sclk_i; endproperty
   a_mux_oe: assert property (p_mux_oe) else $error("shared wire not on fall");
   property p_fix_oe; !mux_variant_i && $rose(dout_oe_o) |-> $past(sclk_i) && sclk_i; endproperty
   a_fix_oe: assert property (p_fix_oe) else $error("fixed driver not on rise");
endmodule
bind adc_serial_port adc_serial_port_properties props_u (.core_clk_i, .rstn_i, .mux_variant_i,
   .cs_n_i, .sclk_i, .dout_o, .dout_oe_o, .powered_o, .sample_o, .convert_o);

/* tb/host_model.sv */
// host controller driving select, shift clock and serial input
`timescale 1ns/1ps
module host_model (
   input wire logic core_clk_i,
   input wire logic dout_i,
   output logic cs_n_o,
   output logic sclk_o,
   output logic din_o
);
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      din_o = 1'b0;
   end
   // lead zeros, start and config word, then ones that must be ignored
   task automatic frame(input int lead, input logic [4:0] word, output logic [15:0] rx);
      logic [15:0] tx;
      tx = {word, 11'h7ff};
      rx = 16'h0;
      cs_n_o <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      for (int i = 0; i < lead + 16; i++) begin
         din_o <= (i < lead) ? 1'b0 : tx[lead + 15 - i];
         repeat (4) @(posedge core_clk_i);
         sclk_o <= 1'b1;
         repeat (4) @(posedge core_clk_i);
         rx = {rx[14:0], dout_i};
         sclk_o <= 1'b0;
      end
   endtask
   task automatic finish();
      cs_n_o <= 1'b1;
      din_o <= ~din_o;
      repeat (4) @(posedge core_clk_i);
   endtask
endmodule

/* tb/adc_serial_port_test.sv */
// self-checking bench for the serial converter port
`timescale 1ns/1ps
module adc_serial_port_test;
   logic core_clk_i = 1'b0, rstn_i = 1'b0, mux_variant_i = 1'b1;
   logic cs_n_i, sclk_i, din_i, dout_o, dout_oe_o, powered_o, sample_o, convert_o;
   logic single_ended_select_o, odd_sign_o;
   logic [7:0] conv_data_i = 8'h00, result_o;
   logic [7:0] vals [4] = '{8'h80, 8'h01, 8'hff, 8'h5a};
   logic [15:0] rx;
   int miscompares = 0, tests_run = 0, cycles = 0;
   adc_serial_port dut_u (.core_clk_i, .rstn_i, .mux_variant_i, .cs_n_i, .sclk_i, .din_i,
      .dout_o, .dout_oe_o, .conv_data_i, .powered_o, .sample_o, .convert_o,
      .single_ended_select_o, .odd_sign_o, .result_o);
   host_model host_u (.core_clk_i, .dout_i(dout_o), .cs_n_o(cs_n_i), .sclk_o(sclk_i),
      .din_o(din_i));
   initial forever #12.5 core_clk_i = ~core_clk_i;
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      tests_run++;
      if (seen !== want) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   task automatic results();
      $display("tests run %0d, miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         results();
      end
   end
   initial begin
      repeat (5) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         conv_data_i <= vals[k];
         host_u.frame(k, {1'b1, k[1:0], ~k[1:0]}, rx);
         check(rx, {7'h0, vals[k], 1'b0});
         check({13'h0, single_ended_select_o, odd_sign_o, dout_oe_o}, {13'h0, k[1:0], 1'b1});
         check({8'h0, result_o}, {8'h0, vals[k]});
         host_u.finish();
         check({13'h0, powered_o, dout_oe_o, convert_o}, 16'h0);
         $display("mux test %0d done", k);
      end
      mux_variant_i <= 1'b0;
      conv_data_i <= 8'hc3;
      host_u.frame(0, 5'h1f, rx);
      check(rx, {3'h0, 8'hc3, 5'h0});
      check({14'h0, single_ended_select_o, odd_sign_o}, 16'h0);
      host_u.finish();
      $display("fixed test done");
      results();
   end
endmodule
